// *** ftc_line_manager.sv ***
// Overview of operation
// R01 - Low transmit input drives bus dominant
// R02 - Receive output shows bus level, low dominant
// R03 - Normal mode: error low on detected failure
// R04 - Standby/sleep: error low after wake-up
// R05 - Power-on standby: error shows power-on flag
// R06 - Standby-control and enable pins select mode
// R07 - Local wake registers on both edges
// R08 - Wake-up switches regulator inhibit on
// R09 - Long low transmit input disables transmitter
// R10 - High transmit input clears time-out, re-enables
// R11 - Detector active in normal mode, reconfigures
// R12 - Benign failures keep differential full operation
// R13 - CANH high: CANH single-wire, then CANL
// R14 - CANH to battery: CANL receive, CANH off
// R15 - CANL to ground: CANH receive, CANL off
// R16 - CANL high: CANH receive, CANL off
// R17 - Wires shorted: CANH receive, CANL off
// R18 - Recessive period leaves failure 3/3a/6 mode
// R19 - Failure 4/7 time-out: CANL off, pull-up
// R20 - Recessive differential period restores differential mode
// R21 - Recovered failure returns error output high
// R22 - Open wire flagged only between talking nodes
// R23 - Pin pair decodes into four modes
// R24 - Normal mode clears power-on and wake flags
// R25 - Low logic supply forces mode pins low
// R26 - Every time-out is a parameterised counter
//
// The register addresses and register access over APB were left to the implementer.
`timescale 1ns/100ps

module ftc_line_manager #(
  parameter int unsigned TXD_TO_CYC = ftc_pkg::TXD_TO_CYC,
  parameter int unsigned H1_CYC     = ftc_pkg::H1_CYC,
  parameter int unsigned H2_CYC     = ftc_pkg::H2_CYC,
  parameter int unsigned L6_CYC     = ftc_pkg::L6_CYC,
  parameter int unsigned F47_CYC    = ftc_pkg::F47_CYC,
  parameter int unsigned RECH_CYC   = ftc_pkg::REC_CYC,
  parameter int unsigned RECL_CYC   = ftc_pkg::REC_CYC,
  parameter int unsigned REC47_CYC  = ftc_pkg::REC_CYC,
  parameter int unsigned WAKE_CYC   = ftc_pkg::WAKE_CYC,
  parameter int unsigned SLEEP_CYC  = ftc_pkg::SLEEP_CYC
) (
  // Clock and reset
  input  wire logic                        clk_i,
  input  wire logic                        rst_i,
  // Controller side
  input  wire logic                        txd_i,
  input  wire logic                        stb_i,
  input  wire logic                        en_i,
  output logic                             rxd_o,
  output logic                             err_n_o,
  // Local wake and supply status
  input  wire logic                        wake_n_i,
  input  wire logic                        vcc_low_i,
  output logic                             regulator_inhibit_out_o,
  // Bus comparators
  input  wire logic                        canh_high_i,
  input  wire logic                        canl_high_i,
  input  wire logic                        diff_dom_i,
  input  wire logic                        canh_rx_dom_i,
  input  wire logic                        canl_rx_dom_i,
  input  wire logic                        open_wire_i,
  input  wire logic                        bus_wake_i,
  // Drivers and terminations
  output logic                             canh_drive_o,
  output logic                             canl_drive_o,
  output logic                             high_wire_termination_weak_o,
  output logic                             low_wire_termination_weak_o,
  output logic                             low_wire_termination_bat_o,
  // APB slave
  input  wire logic                        psel_i,
  input  wire logic                        penable_i,
  input  wire logic                        pwrite_i,
  input  wire logic [ftc_pkg::APB_AW-1:0]  paddr_i,
  input  wire logic [ftc_pkg::APB_DW-1:0]  pwdata_i,
  output logic [ftc_pkg::APB_DW-1:0]       prdata_o,
  output logic                             pready_o,
  output logic                             pslverr_o
);

  // --------
  // State
  // --------
  typedef struct packed {
    logic [ftc_pkg::NP-1:0]     s1;
    logic [ftc_pkg::NP-1:0]     s2;
    logic                       bwake_d;
    logic                       wake_flt;
    logic                       tx_dis;
    logic                       wake_flag;
    logic                       por_flag;
    logic                       regulator_inhibit_out;
    logic                       det_en;
    ftc_pkg::ftc_fail_t         fs;
    logic                       canh_drv;
    logic                       canl_drv;
    logic                       rth_weak;
    logic                       rtl_weak;
    logic                       rtl_bat;
    logic                       rxd;
    logic                       err_n;
    logic                       pready;
    logic                       pslverr;
    logic [ftc_pkg::APB_DW-1:0] prdata;
  } ftc_st_t;

  // Power-on flag and inhibit start set: reset stands for battery power-on
  localparam ftc_st_t ST_RST = '{
    s1:        '1,
    s2:        '1,
    bwake_d:   1'b1,
    wake_flt:  1'b1,
    por_flag:  1'b1,
    regulator_inhibit_out:       1'b1,
    det_en:    1'b1,
    fs:        ftc_pkg::FS_NONE,
    rxd:       1'b1,
    err_n:     1'b1,
    default:   '0
  };

  ftc_st_t st;
  ftc_st_t next_st;

  logic [ftc_pkg::NP-1:0] pins;
  logic [ftc_pkg::NT-1:0] t_run;
  logic [ftc_pkg::NT-1:0] t_done;

  assign pins = {bus_wake_i, open_wire_i, canl_rx_dom_i, canh_rx_dom_i, diff_dom_i,
                 canl_high_i, canh_high_i, vcc_low_i, wake_n_i, en_i, stb_i, txd_i};

  // --------
  // Time-out counters
  // --------
  function automatic int unsigned t_len(input int idx);
    case (idx)
      ftc_pkg::T_TXD:   t_len = TXD_TO_CYC;
      ftc_pkg::T_H1:    t_len = H1_CYC;
      ftc_pkg::T_H2:    t_len = H2_CYC;
      ftc_pkg::T_L6:    t_len = L6_CYC;
      ftc_pkg::T_F47:   t_len = F47_CYC;
      ftc_pkg::T_RECH:  t_len = RECH_CYC;
      ftc_pkg::T_RECL:  t_len = RECL_CYC;
      ftc_pkg::T_REC47: t_len = REC47_CYC;
      ftc_pkg::T_WAKE:  t_len = WAKE_CYC;
      default:          t_len = SLEEP_CYC;
    endcase
  endfunction

  for (genvar g = 0; g < ftc_pkg::NT; g++)
  begin : g_tmr
    ftc_timer #(
      .W   (ftc_pkg::TMR_W),
      .LEN (t_len(g))
    ) u_tmr (
      .clk_i  (clk_i),
      .rst_i  (rst_i),
      .run_i  (t_run[g]),
      .done_o (t_done[g])
    ); // R26
  end

  // --------
  // Next-state logic
  // --------
  logic                       txd_s;
  logic                       wake_s;
  logic                       h_hi;
  logic                       l_hi;
  logic                       d_dom;
  logic                       stb_eff;
  logic                       en_eff;
  logic                       normal;
  logic                       det_act;
  logic                       wake_ev;
  logic                       rx_dom;
  logic                       tx_dom;
  logic                       h_on;
  logic                       l_on;
  logic                       setup;
  logic                       wr_acc;
  logic [ftc_pkg::APB_DW-1:0] stat;
  ftc_pkg::ftc_mode_t         mode;

  always_comb
  begin
    next_st = st;
    next_st.s1 = pins;
    next_st.s2 = st.s1;
    txd_s  = st.s2[ftc_pkg::P_TXD];
    wake_s = st.s2[ftc_pkg::P_WAKE];
    h_hi   = st.s2[ftc_pkg::P_HHI];
    l_hi   = st.s2[ftc_pkg::P_LHI];
    d_dom  = st.s2[ftc_pkg::P_DIFF];
    next_st.bwake_d = st.s2[ftc_pkg::P_BWAKE];

    // Fail-safe: a sagging logic supply reads as both pins low
    stb_eff = st.s2[ftc_pkg::P_STB] & ~st.s2[ftc_pkg::P_VLOW]; // R25
    en_eff  = st.s2[ftc_pkg::P_EN] & ~st.s2[ftc_pkg::P_VLOW]; // R25
    mode    = ftc_pkg::ftc_mode_t'({stb_eff, en_eff}); // R06 R23
    normal  = (mode == ftc_pkg::MD_NORMAL);
    det_act = normal & st.det_en; // R11

    // Transmit dominant time-out
    t_run = '0;
    t_run[ftc_pkg::T_TXD] = ~txd_s; // R09
    if (txd_s)
      next_st.tx_dis = 1'b0; // R10
    else if (t_done[ftc_pkg::T_TXD])
      next_st.tx_dis = 1'b1; // R09

    // Wake-up: level must settle for the filter time after either edge
    t_run[ftc_pkg::T_WAKE]  = (wake_s != st.wake_flt); // R07
    t_run[ftc_pkg::T_SLEEP] = (mode == ftc_pkg::MD_GOTO_SLEEP);
    wake_ev = 1'b0;
    if (t_done[ftc_pkg::T_WAKE] && (wake_s != st.wake_flt))
    begin
      next_st.wake_flt = wake_s;
      wake_ev = 1'b1; // R07
    end
    if (st.s2[ftc_pkg::P_BWAKE] && !st.bwake_d && !normal)
      wake_ev = 1'b1;

    // Inhibit: any wake or a high standby pin wins over going to sleep
    if (wake_ev || stb_eff)
      next_st.regulator_inhibit_out = 1'b1; // R08
    else if (t_done[ftc_pkg::T_SLEEP])
      next_st.regulator_inhibit_out = 1'b0;

    if (normal)
    begin
      next_st.wake_flag = 1'b0; // R24
      next_st.por_flag  = 1'b0; // R24
    end
    else if (wake_ev)
      next_st.wake_flag = 1'b1;

    // Failure detector qualifying periods
    t_run[ftc_pkg::T_H1]    = det_act & h_hi & (st.fs == ftc_pkg::FS_NONE); // R13
    t_run[ftc_pkg::T_H2]    = det_act & h_hi & (st.fs == ftc_pkg::FS_H_SW); // R13
    t_run[ftc_pkg::T_RECH]  = ~h_hi & ((st.fs == ftc_pkg::FS_H_SW) |
                                       (st.fs == ftc_pkg::FS_H_CANL)); // R18
    t_run[ftc_pkg::T_L6]    = det_act & l_hi & (st.fs == ftc_pkg::FS_NONE); // R16
    t_run[ftc_pkg::T_RECL]  = ~l_hi & (st.fs == ftc_pkg::FS_L_BAT); // R18
    t_run[ftc_pkg::T_F47]   = det_act & d_dom & ~h_hi & ~l_hi &
                              (st.fs == ftc_pkg::FS_NONE); // R19
    t_run[ftc_pkg::T_REC47] = ~d_dom & (st.fs == ftc_pkg::FS_L_GND); // R20

    case (st.fs)
      ftc_pkg::FS_NONE:
      begin
        if (t_done[ftc_pkg::T_H1])
          next_st.fs = ftc_pkg::FS_H_SW; // R13
        else if (t_done[ftc_pkg::T_L6])
          next_st.fs = ftc_pkg::FS_L_BAT; // R16
        else if (t_done[ftc_pkg::T_F47])
          next_st.fs = ftc_pkg::FS_L_GND; // R19
      end
      ftc_pkg::FS_H_SW:
      begin
        if (t_done[ftc_pkg::T_H2])
          next_st.fs = ftc_pkg::FS_H_CANL; // R13 R14
        else if (t_done[ftc_pkg::T_RECH])
          next_st.fs = ftc_pkg::FS_NONE; // R18
      end
      ftc_pkg::FS_H_CANL:
      begin
        if (t_done[ftc_pkg::T_RECH])
          next_st.fs = ftc_pkg::FS_NONE; // R18
      end
      ftc_pkg::FS_L_BAT:
      begin
        if (t_done[ftc_pkg::T_RECL])
          next_st.fs = ftc_pkg::FS_NONE; // R18
      end
      ftc_pkg::FS_L_GND:
      begin
        if (t_done[ftc_pkg::T_REC47])
          next_st.fs = ftc_pkg::FS_NONE; // R20
      end
      default:
      begin
        next_st.fs = ftc_pkg::FS_NONE;
      end
    endcase
    if (!st.det_en)
      next_st.fs = ftc_pkg::FS_NONE;

    // Driver, termination and receiver selection per configuration
    rx_dom = d_dom; // R12
    h_on   = 1'b1;
    l_on   = 1'b1;
    next_st.rth_weak = 1'b0;
    next_st.rtl_weak = 1'b0;
    case (st.fs)
      ftc_pkg::FS_H_SW:
      begin
        rx_dom = st.s2[ftc_pkg::P_HRX]; // R13
      end
      ftc_pkg::FS_H_CANL:
      begin
        rx_dom = st.s2[ftc_pkg::P_LRX]; // R13 R14
        h_on   = 1'b0; // R14
        next_st.rth_weak = 1'b1; // R13 R14
      end
      ftc_pkg::FS_L_BAT,
      ftc_pkg::FS_L_GND:
      begin
        rx_dom = st.s2[ftc_pkg::P_HRX]; // R15 R16 R17
        l_on   = 1'b0; // R15 R16 R17 R19
        next_st.rtl_weak = 1'b1; // R15 R16 R17 R19
      end
      default:
      begin
        rx_dom = d_dom; // R12
      end
    endcase

    // A time-out disable also stops frames already under way on the wire
    tx_dom = normal & ~txd_s & ~st.tx_dis; // R01
    next_st.canh_drv = tx_dom & h_on; // R01
    next_st.canl_drv = tx_dom & l_on; // R01
    next_st.rtl_bat  = ~normal;

    case (mode)
      ftc_pkg::MD_NORMAL:
      begin
        next_st.rxd   = ~rx_dom; // R02
        // Open-wire comparator only fires between talking nodes, so this toggles
        next_st.err_n = ~((st.fs != ftc_pkg::FS_NONE) |
                          st.s2[ftc_pkg::P_OPEN]); // R03 R21 R22
      end
      ftc_pkg::MD_PWR_STBY:
      begin
        next_st.rxd   = ~st.wake_flag;
        next_st.err_n = ~st.por_flag; // R05
      end
      default:
      begin
        next_st.rxd   = ~st.wake_flag;
        next_st.err_n = ~st.wake_flag; // R04
      end
    endcase

    // APB: zero-wait answer, data captured in the setup cycle
    stat = ftc_pkg::RD_ZERO;
    stat[ftc_pkg::ST_FS_LSB +: $bits(ftc_pkg::ftc_fail_t)] = st.fs;
    stat[ftc_pkg::ST_MODE_LSB +: $bits(ftc_pkg::ftc_mode_t)] = mode;
    stat[ftc_pkg::ST_TXDIS] = st.tx_dis;
    stat[ftc_pkg::ST_WAKE]  = st.wake_flag;
    stat[ftc_pkg::ST_POR]   = st.por_flag;
    stat[ftc_pkg::ST_INH]   = st.regulator_inhibit_out;
    stat[ftc_pkg::ST_OPEN]  = st.s2[ftc_pkg::P_OPEN];
    setup  = psel_i & ~penable_i;
    wr_acc = psel_i & penable_i & st.pready & pwrite_i;
    next_st.pready  = setup;
    next_st.pslverr = 1'b0;
    if (setup)
    begin
      next_st.prdata = ftc_pkg::RD_ZERO;
      if (paddr_i == ftc_pkg::REG_CTRL)
        next_st.prdata[ftc_pkg::CTRL_DET_EN] = st.det_en;
      else if (paddr_i == ftc_pkg::REG_STATUS)
        next_st.prdata = stat;
      else
        next_st.pslverr = 1'b1;
    end
    if (wr_acc && (paddr_i == ftc_pkg::REG_CTRL))
      next_st.det_en = pwdata_i[ftc_pkg::CTRL_DET_EN];
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      st <= ST_RST;
    else
      st <= next_st;
  end

  // --------
  // Outputs
  // --------
  assign rxd_o                        = st.rxd;
  assign err_n_o                      = st.err_n;
  assign regulator_inhibit_out_o      = st.regulator_inhibit_out;
  assign canh_drive_o                 = st.canh_drv;
  assign canl_drive_o                 = st.canl_drv;
  assign high_wire_termination_weak_o = st.rth_weak;
  assign low_wire_termination_weak_o  = st.rtl_weak;
  assign low_wire_termination_bat_o   = st.rtl_bat;
  assign prdata_o                     = st.prdata;
  assign pready_o                     = st.pready;
  assign pslverr_o                    = st.pslverr;

endmodule

// *** ftc_pkg.sv ***
package ftc_pkg;

  // --------
  // Time base
  // --------
  localparam int unsigned CLK_HZ     = 10_000_000;
  localparam int unsigned HZ_PER_MHZ = 1_000_000;
  localparam int unsigned CYC_PER_US = CLK_HZ / HZ_PER_MHZ;
  localparam int unsigned TMR_W      = 16;

  // --------
  // Time-outs in microseconds and derived cycle counts
  // --------
  localparam int unsigned TXD_TO_US  = 2000;
  localparam int unsigned H1_US      = 100;
  localparam int unsigned H2_US      = 500;
  localparam int unsigned L6_US      = 50;
  localparam int unsigned F47_US     = 200;
  localparam int unsigned REC_US     = 100;
  localparam int unsigned WAKE_US    = 40;
  localparam int unsigned SLEEP_US   = 50;
  localparam int unsigned TXD_TO_CYC = TXD_TO_US * CYC_PER_US;
  localparam int unsigned H1_CYC     = H1_US * CYC_PER_US;
  localparam int unsigned H2_CYC     = H2_US * CYC_PER_US;
  localparam int unsigned L6_CYC     = L6_US * CYC_PER_US;
  localparam int unsigned F47_CYC    = F47_US * CYC_PER_US;
  localparam int unsigned REC_CYC    = REC_US * CYC_PER_US;
  localparam int unsigned WAKE_CYC   = WAKE_US * CYC_PER_US;
  localparam int unsigned SLEEP_CYC  = SLEEP_US * CYC_PER_US;

  // --------
  // Timer slots
  // --------
  localparam int T_TXD   = 0;
  localparam int T_H1    = 1;
  localparam int T_H2    = 2;
  localparam int T_L6    = 3;
  localparam int T_F47   = 4;
  localparam int T_RECH  = 5;
  localparam int T_RECL  = 6;
  localparam int T_REC47 = 7;
  localparam int T_WAKE  = 8;
  localparam int T_SLEEP = 9;
  localparam int NT      = 10;

  // --------
  // Synchronised pin slots
  // --------
  localparam int P_TXD   = 0;
  localparam int P_STB   = 1;
  localparam int P_EN    = 2;
  localparam int P_WAKE  = 3;
  localparam int P_VLOW  = 4;
  localparam int P_HHI   = 5;
  localparam int P_LHI   = 6;
  localparam int P_DIFF  = 7;
  localparam int P_HRX   = 8;
  localparam int P_LRX   = 9;
  localparam int P_OPEN  = 10;
  localparam int P_BWAKE = 11;
  localparam int NP      = 12;

  // --------
  // Modes and failure configurations
  // --------
  typedef enum logic [1:0] {
    MD_SLEEP      = 2'b00,
    MD_GOTO_SLEEP = 2'b01,
    MD_PWR_STBY   = 2'b10,
    MD_NORMAL     = 2'b11
  } ftc_mode_t;

  typedef enum logic [2:0] {
    FS_NONE   = 3'b000,
    FS_H_SW   = 3'b001,
    FS_H_CANL = 3'b010,
    FS_L_BAT  = 3'b011,
    FS_L_GND  = 3'b100
  } ftc_fail_t;

  // --------
  // APB register map
  // --------
  localparam int unsigned APB_AW     = 8;
  localparam int unsigned APB_DW     = 32;
  localparam logic [7:0]  REG_CTRL   = 8'h00;
  localparam logic [7:0]  REG_STATUS = 8'h04;
  localparam logic [31:0] RD_ZERO    = 32'h0000_0000;
  localparam int CTRL_DET_EN = 0;
  localparam int ST_FS_LSB   = 0;
  localparam int ST_MODE_LSB = 4;
  localparam int ST_TXDIS    = 8;
  localparam int ST_WAKE     = 9;
  localparam int ST_POR      = 10;
  localparam int ST_INH      = 11;
  localparam int ST_OPEN     = 12;

endpackage

// *** ftc_timer.sv ***
`timescale 1ns/100ps

module ftc_timer #(
  parameter int unsigned W   = 16,
  parameter int unsigned LEN = 100
) (
  // Clock and reset
  input  wire logic clk_i,
  input  wire logic rst_i,
  // Qualifying condition and expiry
  input  wire logic run_i,
  output logic      done_o
);

  typedef struct packed {
    logic [W-1:0] cnt;
    logic         done;
  } ftc_tmr_t;

  localparam logic [W-1:0] LAST = W'(LEN - 1);
  localparam logic [W-1:0] ONE  = W'(1);

  ftc_tmr_t st;
  ftc_tmr_t next_st;

  // Condition must hold without a break; any gap restarts the count
  always_comb
  begin
    next_st = st;
    if (!run_i)
    begin
      next_st.cnt  = '0;
      next_st.done = 1'b0;
    end
    else
    begin
      if (st.cnt != LAST)
        next_st.cnt = st.cnt + ONE;
      next_st.done = (st.cnt == LAST);
    end
  end

  always_ff @(posedge clk_i or posedge rst_i)
  begin
    if (rst_i)
      st <= '0;
    else
      st <= next_st;
  end

  assign done_o = st.done;

endmodule

// *** ftc_line_manager_chk.sv ***
`timescale 1ns/100ps

module ftc_line_manager_chk #(
  parameter int unsigned TXD_TO_CYC = 20000
) (
  // Clock and reset
  input  wire logic        clk_i,
  input  wire logic        rst_i,
  // Controller pins
  input  wire logic        txd_i,
  input  wire logic        stb_i,
  input  wire logic        en_i,
  input  wire logic        vcc_low_i,
  // APB
  input  wire logic        psel_i,
  input  wire logic        penable_i,
  input  wire logic [7:0]  paddr_i,
  input  wire logic [31:0] prdata_o,
  input  wire logic        pready_o,
  input  wire logic        pslverr_o,
  // Line side
  input  wire logic        canh_drive_o,
  input  wire logic        canl_drive_o,
  input  wire logic        high_wire_termination_weak_o,
  input  wire logic        low_wire_termination_weak_o,
  input  wire logic        low_wire_termination_bat_o,
  input  wire logic        regulator_inhibit_out_o
);
  // --------
  // Drive length counter
  // --------
  int unsigned drv_cnt;

  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
      drv_cnt <= 0;
    else if (canh_drive_o || canl_drive_o)
      drv_cnt <= drv_cnt + 1;
    else
      drv_cnt <= 0;

  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  a_apb_ready: assert property (psel_i && !penable_i |=> pready_o)
    else $error("no ready after setup");
  a_ready_once: assert property (pready_o |=> !pready_o)
    else $error("ready held too long");
  a_bad_addr: assert property (psel_i && !penable_i && paddr_i != ftc_pkg::REG_CTRL
    && paddr_i != ftc_pkg::REG_STATUS |=> pslverr_o && prdata_o == ftc_pkg::RD_ZERO)
    else $error("unmapped access not refused");
  a_txd_idle: assert property (txd_i [*5] |=> !canh_drive_o && !canl_drive_o)
    else $error("bus driven with transmit high");
  a_txd_limit: assert property (drv_cnt <= TXD_TO_CYC + 6)
    else $error("dominant drive too long");
  a_inh_stb: assert property ((stb_i && !vcc_low_i) [*5] |=> regulator_inhibit_out_o)
    else $error("inhibit low with standby pin high");
  a_sleep_bias: assert property ((!stb_i || !en_i) [*5] |=> low_wire_termination_bat_o)
    else $error("low wire not biased outside normal");
  a_vcc_force: assert property (vcc_low_i [*5] |=> low_wire_termination_bat_o)
    else $error("low supply did not force low power");
  a_norm_bias: assert property ((stb_i && en_i && !vcc_low_i) [*5]
    |=> !low_wire_termination_bat_o)
    else $error("low wire biased in normal mode");
  a_canh_weak: assert property (high_wire_termination_weak_o |-> !canh_drive_o)
    else $error("high driver on with weak termination");
  a_canl_weak: assert property (low_wire_termination_weak_o |-> !canl_drive_o)
    else $error("low driver on with weak termination");
  a_one_fail: assert property (!(high_wire_termination_weak_o
    && low_wire_termination_weak_o))
    else $error("both terminations weak");
endmodule

bind ftc_line_manager ftc_line_manager_chk #(.TXD_TO_CYC(TXD_TO_CYC)) u_chk (
  .clk_i(clk_i), .rst_i(rst_i), .txd_i(txd_i), .stb_i(stb_i), .en_i(en_i),
  .vcc_low_i(vcc_low_i), .psel_i(psel_i), .penable_i(penable_i), .paddr_i(paddr_i),
  .prdata_o(prdata_o), .pready_o(pready_o), .pslverr_o(pslverr_o),
  .canh_drive_o(canh_drive_o), .canl_drive_o(canl_drive_o),
  .high_wire_termination_weak_o(high_wire_termination_weak_o),
  .low_wire_termination_weak_o(low_wire_termination_weak_o),
  .low_wire_termination_bat_o(low_wire_termination_bat_o),
  .regulator_inhibit_out_o(regulator_inhibit_out_o));

// *** ftc_ctrl_model.sv ***
`timescale 1ns/100ps

module ftc_ctrl_model (
  // Clock and reset
  input  wire logic       clk_i,
  input  wire logic       rst_i,
  // Commands from the sequence
  input  wire logic [1:0] mode_i,
  input  wire logic       tx_i,
  // Controller pins
  output logic            stb_o,
  output logic            en_o,
  output logic            txd_o
);
  // Both mode pins move on one edge, so no stray mode is decoded between them
  always_ff @(posedge clk_i or posedge rst_i)
    if (rst_i)
    begin
      {stb_o, en_o} <= 2'h0;
      txd_o         <= 1'h1;
    end
    else
    begin
      {stb_o, en_o} <= mode_i;
      txd_o         <= tx_i;
    end
endmodule

// *** ftc_line_manager_tb_top.sv ***
`timescale 1ns/100ps

module ftc_line_manager_tb_top;
  // --------
  // Shortened time-outs keep the run brief
  // --------
  localparam int TO  = 16;
  localparam int H1  = 10;
  localparam int H2  = 12;
  localparam int L6  = 8;
  localparam int F47 = 14;
  localparam int RC  = 10;
  localparam int WK  = 8;
  localparam int SL  = 10;
  logic        clk_i, rst_i, tx, wake_n, vlow, hhi, lhi, ddom, hrx, lrx, openw, bwake;
  logic        stb, en, txd, rxd, err_n, regulator_inhibit_out, hdrv, ldrv, hweak, lweak, lbat;
  logic        psel, pen, pwr, prdy, perr, e;
  logic [1:0]  mode;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata, q;
  int          miscompares, total_checks, cycles;

  initial
  begin
    clk_i = 1'h0;
    forever #50 clk_i = ~clk_i;
  end

  ftc_ctrl_model ctrl (.clk_i(clk_i), .rst_i(rst_i), .mode_i(mode), .tx_i(tx),
    .stb_o(stb), .en_o(en), .txd_o(txd));

  ftc_line_manager #(.TXD_TO_CYC(TO), .H1_CYC(H1), .H2_CYC(H2), .L6_CYC(L6), .F47_CYC(F47),
    .RECH_CYC(RC), .RECL_CYC(RC), .REC47_CYC(RC), .WAKE_CYC(WK), .SLEEP_CYC(SL)) uut (
    .clk_i(clk_i), .rst_i(rst_i), .txd_i(txd), .stb_i(stb), .en_i(en), .rxd_o(rxd),
    .err_n_o(err_n), .wake_n_i(wake_n), .vcc_low_i(vlow), .regulator_inhibit_out_o(regulator_inhibit_out),
    .canh_high_i(hhi), .canl_high_i(lhi), .diff_dom_i(ddom), .canh_rx_dom_i(hrx),
    .canl_rx_dom_i(lrx), .open_wire_i(openw), .bus_wake_i(bwake), .canh_drive_o(hdrv),
    .canl_drive_o(ldrv), .high_wire_termination_weak_o(hweak),
    .low_wire_termination_weak_o(lweak), .low_wire_termination_bat_o(lbat),
    .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(paddr), .pwdata_i(pwdata),
    .prdata_o(prdata), .pready_o(prdy), .pslverr_o(perr));

  // --------
  // Shared tasks
  // --------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    total_checks++;
    if (got !== exp)
    begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic chb(input logic got, input logic exp);
    chk({31'h0, got}, {31'h0, exp});
  endtask

  // Ends on a falling edge, where outputs are settled
  task automatic look(input int n);
    repeat (n) @(posedge clk_i);
    @(negedge clk_i);
  endtask

  task automatic apb(input logic w, input logic [7:0] a, input logic [31:0] d = 32'h0000_0000);
    int n;
    n = 0;
    @(posedge clk_i);
    {psel, pwr, paddr, pwdata} <= {1'h1, w, a, d};
    @(posedge clk_i);
    pen <= 1'h1;
    @(posedge clk_i);
    while (prdy !== 1'h1 && n < 20)
    begin
      n++;
      @(posedge clk_i);
    end
    miscompares += (n == 20);
    {q, e} = {prdata, perr};
    {psel, pen} <= 2'h0;
  endtask

  task automatic st(input logic [31:0] m, input logic [31:0] x);
    apb(1'h0, ftc_pkg::REG_STATUS);
    chk(q & m, x);
  endtask

  task automatic tally_and_finish;
    $display("checks %0d mismatches %0d", total_checks, miscompares);
    if (miscompares == 0 && total_checks > 0)
      $display("ALL CHECKS OK");
    else
      $display("CHECKS NOT OK");
    $finish;
  endtask

  always @(posedge clk_i)
  begin
    cycles++;
    if (cycles == 6000)
    begin
      miscompares++;
      tally_and_finish;
    end
  end

  // --------
  // Test sequence
  // --------
  initial
  begin
    {hhi, lhi, ddom, hrx, lrx, openw, bwake, vlow, psel, pen, pwr} = '0;
    {rst_i, tx, wake_n, mode, paddr, pwdata} = {3'h7, 2'h0, 8'h00, 32'h0000_0000};
    {miscompares, total_checks, cycles} = '0;
    repeat (4) @(posedge clk_i);
    rst_i <= 1'h0;
    look(1);
    chk({rxd, err_n, regulator_inhibit_out, hdrv, ldrv}, 32'h0000_001C);
    apb(1'h0, ftc_pkg::REG_CTRL);
    chk(q, 32'h0000_0001);
    apb(1'h1, ftc_pkg::REG_CTRL, 32'h0000_0000);
    apb(1'h0, ftc_pkg::REG_CTRL);
    chk(q, 32'h0000_0000);
    apb(1'h1, ftc_pkg::REG_CTRL, 32'h0000_0001);
    apb(1'h0, 8'h08);
    chk({q[30:0], e}, 32'h0000_0001);
    $display("test registers done");
    @(posedge clk_i) mode <= ftc_pkg::MD_PWR_STBY;
    look(6);
    chb(err_n, 1'h0);
    st(32'h0000_0400, 32'h0000_0400);
    @(posedge clk_i) mode <= ftc_pkg::MD_NORMAL;
    look(6);
    chk({err_n, lbat}, 32'h0000_0002);
    st(32'h0000_0400, 32'h0000_0000);
    $display("test modes done");
    @(posedge clk_i) tx <= 1'h0;
    look(5);
    chb(hdrv & ldrv, 1'h1);
    look(TO + 6);
    chb(hdrv | ldrv, 1'h0);
    @(posedge clk_i) tx <= 1'h1;
    look(4);
    @(posedge clk_i) tx <= 1'h0;
    look(5);
    chb(hdrv & ldrv, 1'h1);
    @(posedge clk_i) tx <= 1'h1;
    look(5);
    chb(hdrv | ldrv, 1'h0);
    $display("test transmit done");
    @(posedge clk_i) {lhi, hrx} <= 2'h3;
    look(L6 + 8);
    chk({lweak, ldrv, rxd, err_n}, 32'h0000_0008);
    st(32'h0000_0007, {29'h0, ftc_pkg::FS_L_BAT});
    @(posedge clk_i) {lhi, hrx} <= 2'h0;
    look(RC + 8);
    chk({lweak, err_n}, 32'h0000_0001);
    @(posedge clk_i) {hhi, lrx} <= 2'h3;
    look(H1 + 6);
    st(32'h0000_0007, {29'h0, ftc_pkg::FS_H_SW});
    chb(err_n, 1'h0);
    look(H2 + 6);
    st(32'h0000_0007, {29'h0, ftc_pkg::FS_H_CANL});
    chk({hweak, hdrv, rxd}, 32'h0000_0004);
    @(posedge clk_i) {hhi, lrx} <= 2'h0;
    look(RC + 8);
    st(32'h0000_0007, {29'h0, ftc_pkg::FS_NONE});
    @(posedge clk_i) ddom <= 1'h1;
    look(5);
    chb(rxd, 1'h0);
    look(F47 + 6);
    chk({lweak, ldrv}, 32'h0000_0002);
    st(32'h0000_0007, {29'h0, ftc_pkg::FS_L_GND});
    @(posedge clk_i) ddom <= 1'h0;
    look(RC + 8);
    st(32'h0000_0007, {29'h0, ftc_pkg::FS_NONE});
    chb(err_n, 1'h1);
    @(posedge clk_i) openw <= 1'h1;
    look(5);
    chb(err_n, 1'h0);
    @(posedge clk_i) openw <= 1'h0;
    @(posedge clk_i) vlow <= 1'h1;
    look(6);
    chk({err_n, lbat}, 32'h0000_0003);
    @(posedge clk_i) vlow <= 1'h0;
    $display("test failures done");
    @(posedge clk_i) mode <= ftc_pkg::MD_GOTO_SLEEP;
    look(SL + 8);
    chb(regulator_inhibit_out, 1'h0);
    @(posedge clk_i) mode <= ftc_pkg::MD_SLEEP;
    @(posedge clk_i) wake_n <= 1'h0;
    look(WK + 8);
    chk({regulator_inhibit_out, err_n, rxd}, 32'h0000_0004);
    @(posedge clk_i) mode <= ftc_pkg::MD_NORMAL;
    look(6);
    chb(err_n, 1'h1);
    @(posedge clk_i) mode <= ftc_pkg::MD_SLEEP;
    look(6);
    chb(err_n, 1'h1);
    @(posedge clk_i) wake_n <= 1'h1;
    look(WK + 8);
    chb(err_n, 1'h0);
    $display("test wake done");
    tally_and_finish;
  end
endmodule
